// file: design/dfm_pkg.sv
`default_nettype none

package dfm_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ           = 125_000_000;
    localparam int MS_CYCLES        = CLK_HZ / 1000;
    localparam int EXT_RST_HOLD_MS  = 100;
    localparam int RECOVER_MS       = 1000;
    localparam int BLINK_HALF_MS    = 250;
    // Held longer than the figure: the count rounds the least time up
    localparam int EXT_RST_HOLD_CYC = EXT_RST_HOLD_MS * MS_CYCLES;
    localparam int RECOVER_CYC      = RECOVER_MS * MS_CYCLES;
    localparam int BLINK_HALF_CYC   = BLINK_HALF_MS * MS_CYCLES;
    localparam int WARN_ESC_CYC     = 1000;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_LAST_CODE = 8'h08;
    localparam logic [7:0] REG_HEAT      = 8'h0c;
    localparam logic [7:0] REG_RETRY     = 8'h10;
    localparam logic [7:0] REG_HIST_BASE = 8'h20;
    localparam logic [7:0] REG_HIST_LAST = 8'h3c;

    localparam int CTRL_ALARM_EN_BIT  = 0;
    localparam int CTRL_HIST_CLR_BIT  = 1;
    localparam int STAT_STATE_LSB     = 0;
    localparam int STAT_FAULT_BIT     = 2;
    localparam int STAT_ALARM_BIT     = 3;
    localparam int STAT_WARN_BIT      = 4;
    localparam int STAT_ERR_BIT       = 5;
    localparam int STAT_STOP_BIT      = 6;
    localparam int STAT_HCNT_LSB      = 8;

    localparam int HIST_DEPTH = 8;

    // ----------------------------------------------------------------
    // Fault codes, table order is source priority (index 0 first)
    // ----------------------------------------------------------------
    localparam int NUM_FAULT_SRC = 27;
    localparam logic [7:0] CODE_TAB [0:NUM_FAULT_SRC-1] = '{
        8'h10, 8'h11, 8'h12,        // overcurrent accel/const/decel trip
        8'h20, 8'h21, 8'h22,        // regen overvolt accel/const/decel
        8'h30, 8'h31, 8'h40,        // drive, motor overload, heatsink
        8'h52, 8'h60, 8'h61,        // input phase loss, stall, sync loss
        8'h70, 8'h80, 8'h81,        // brake, ground fault, out phase loss
        8'h90, 8'h91,               // external thermal, thermistor
        8'hb0, 8'hb1, 8'hb2,        // param storage, panel unit, retry
        8'hf5, 8'hc0,               // processor faults
        8'hc4, 8'hc5, 8'hc7,        // current limit, inrush, analog input
        8'hd0, 8'he6                // overspeed, feedback control
    };
    localparam logic [7:0] CODE_STALL_STOP_TRIP = 8'h60;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN        = 2'b00,
        ST_TRIP       = 2'b01,
        ST_RESET_HOLD = 2'b11,
        ST_RECOVER    = 2'b10
    } dfm_state_e;

    typedef enum logic [2:0] {
        DISP_MONITOR = 3'h0,
        DISP_ERROR   = 3'h1,
        DISP_WARN    = 3'h2,
        DISP_ALARM   = 3'h3,
        DISP_FAULT   = 3'h4,
        DISP_RESET   = 3'h5
    } dfm_disp_e;

endpackage

`default_nettype wire

// file: design/dfm_trip_manager.sv
`timescale 1ns/1ps
`default_nettype none

module dfm_trip_manager #(
    parameter int NUM_SRC      = dfm_pkg::NUM_FAULT_SRC,
    parameter int EXT_HOLD_CYC = dfm_pkg::EXT_RST_HOLD_CYC,
    parameter int RECOVER_CYC  = dfm_pkg::RECOVER_CYC,
    parameter int BLINK_CYC    = dfm_pkg::BLINK_HALF_CYC,
    parameter int WARN_ESC_CYC = dfm_pkg::WARN_ESC_CYC
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Register port
    input  wire logic [7:0]           regAddr,
    input  wire logic [31:0]          regWrData,
    input  wire logic                 regWrEn,
    input  wire logic                 regRdEn,
    output logic      [31:0]          regRdData,
    // Condition sources from the drive logic
    input  wire logic [NUM_SRC-1:0]   faultReq,
    input  wire logic                 warnReq,
    input  wire logic                 alarmReq,
    input  wire logic                 errReq,
    input  wire logic [15:0]          heatAdd,
    input  wire logic                 retryPulse,
    // Panel and terminal pins
    input  wire logic                 panelStopKey,
    input  wire logic                 extResetIn,
    input  wire logic                 startCmd,
    // Drive and indication outputs
    output logic                      outputStop,
    output logic                      runEnable,
    output logic                      faultOut,
    output logic                      alarmOut,
    output logic                      errorInd,
    output logic                      warnInd,
    output logic      [2:0]           dispMode,
    output logic                      dispFlash,
    output logic      [7:0]           faultCode
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (NUM_SRC < 1 || NUM_SRC > dfm_pkg::NUM_FAULT_SRC) begin : gChkSrc
        $error("NUM_SRC outside the fault code table");
    end
    if (EXT_HOLD_CYC < 1 || RECOVER_CYC < 1 || BLINK_CYC < 1 ||
        WARN_ESC_CYC < 1) begin : gChkCnt
        $error("cycle counts must be at least one");
    end

    localparam logic [31:0] HOLD_DONE = 32'(EXT_HOLD_CYC);
    localparam logic [31:0] REC_LAST  = 32'(RECOVER_CYC - 1);
    localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);
    localparam logic [31:0] WARN_LAST = 32'(WARN_ESC_CYC - 1);
    localparam logic [3:0]  HIST_FULL = 4'(dfm_pkg::HIST_DEPTH);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        dfm_pkg::dfm_state_e state;
        logic [1:0]          stopSync;
        logic                stopPrev;
        logic [1:0]          extSync;
        logic [1:0]          startSync;
        logic [31:0]         holdCnt;
        logic [31:0]         recCnt;
        logic [31:0]         warnCnt;
        logic [31:0]         blinkCnt;
        logic                blink;
        logic                alarmEn;
        logic [7:0][7:0]     hist;
        logic [3:0]          histCnt;
        logic [7:0]          lastCode;
        logic [31:0]         heat;
        logic [15:0]         retry;
        logic                outputStop;
        logic                runEnable;
        logic                faultOut;
        logic                alarmOut;
        logic                errorInd;
        logic                warnInd;
        dfm_pkg::dfm_disp_e  disp;
        logic                dispFlash;
        logic [31:0]         rdData;
    } dfm_core_s;

    // Power-on counts as a reset: start in recovery with output stopped
    localparam dfm_core_s CORE_RST = '{
        state:      dfm_pkg::ST_RECOVER,
        disp:       dfm_pkg::DISP_MONITOR,
        outputStop: 1'b1,
        blink:      1'b1,
        dispFlash:  1'b1,
        default:    '0
    };

    dfm_core_s st_reg;
    dfm_core_s st_next;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Lowest source index wins when several faults arrive together
    function automatic logic [7:0] firstCode(input logic [NUM_SRC-1:0] req);
        logic [7:0] c;
        c = 8'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                c = dfm_pkg::CODE_TAB[i];
            end
        end
        return c;
    endfunction

    function automatic logic [31:0] readWord(input logic [7:0] a,
                                             input dfm_core_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == dfm_pkg::REG_CTRL) begin
            // Clear bit is an action, it always reads back as zero
            w[dfm_pkg::CTRL_ALARM_EN_BIT] = s.alarmEn;
        end else if (a == dfm_pkg::REG_STATUS) begin
            w[dfm_pkg::STAT_STATE_LSB +: 2] = s.state;
            w[dfm_pkg::STAT_FAULT_BIT]      = s.faultOut;
            w[dfm_pkg::STAT_ALARM_BIT]      = s.alarmOut;
            w[dfm_pkg::STAT_WARN_BIT]       = s.warnInd;
            w[dfm_pkg::STAT_ERR_BIT]        = s.errorInd;
            w[dfm_pkg::STAT_STOP_BIT]       = s.outputStop;
            w[dfm_pkg::STAT_HCNT_LSB +: 4]  = s.histCnt;
        end else if (a == dfm_pkg::REG_LAST_CODE) begin
            w[7:0] = s.lastCode;
        end else if (a == dfm_pkg::REG_HEAT) begin
            w = s.heat;
        end else if (a == dfm_pkg::REG_RETRY) begin
            w[15:0] = s.retry;
        end else if (a >= dfm_pkg::REG_HIST_BASE &&
                     a <= dfm_pkg::REG_HIST_LAST && a[1:0] == 2'b00) begin
            w[7:0] = s.hist[a[4:2]];
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic       stopEdge;
    logic       extLvl;
    logic       extHoldDone;
    logic       warnEsc;
    logic       tripNow;
    logic [7:0] tripCode;
    logic       histClr;
    logic [32:0] heatSum;

    always_comb begin
        st_next = st_reg;

        // Pin synchronisers, first stage feeds only the second
        st_next.stopSync  = {st_reg.stopSync[0], panelStopKey};
        st_next.extSync   = {st_reg.extSync[0], extResetIn};
        st_next.startSync = {st_reg.startSync[0], startCmd};
        st_next.stopPrev  = st_reg.stopSync[1];

        stopEdge    = st_reg.stopSync[1] & ~st_reg.stopPrev;
        extLvl      = st_reg.extSync[1];
        // Enters reset only once held beyond the minimum time
        extHoldDone = extLvl && (st_reg.holdCnt >= HOLD_DONE);
        st_next.holdCnt = !extLvl ? 32'h0000_0000 :
                          (extHoldDone ? st_reg.holdCnt :
                           st_reg.holdCnt + 32'h0000_0001);

        // Persisting warning escalates to a stall-stop fault
        warnEsc = warnReq && (st_reg.warnCnt >= WARN_LAST);
        if (warnReq && st_reg.state == dfm_pkg::ST_RUN && !warnEsc) begin
            st_next.warnCnt = st_reg.warnCnt + 32'h0000_0001;
        end else if (!warnReq || st_reg.state != dfm_pkg::ST_RUN) begin
            st_next.warnCnt = 32'h0000_0000;
        end

        // Error messages never reach the trip path
        tripNow  = (st_reg.state == dfm_pkg::ST_RUN) &&
                   ((|faultReq) || warnEsc);
        tripCode = (|faultReq) ? firstCode(faultReq)
                               : dfm_pkg::CODE_STALL_STOP_TRIP;

        // Register writes
        histClr = 1'b0;
        if (regWrEn && regAddr == dfm_pkg::REG_CTRL) begin
            st_next.alarmEn = regWrData[dfm_pkg::CTRL_ALARM_EN_BIT];
            histClr         = regWrData[dfm_pkg::CTRL_HIST_CLR_BIT];
        end
        if (histClr) begin
            st_next.hist    = '0;
            st_next.histCnt = 4'h0;
        end

        case (st_reg.state)
            dfm_pkg::ST_RUN: begin
                if (extHoldDone) begin
                    st_next.state = dfm_pkg::ST_RESET_HOLD;
                end else if (tripNow) begin
                    st_next.state    = dfm_pkg::ST_TRIP;
                    st_next.lastCode = tripCode;
                    // A push in the clear cycle survives the clear
                    st_next.hist = {st_next.hist[6:0], tripCode};
                    if (st_next.histCnt < HIST_FULL) begin
                        st_next.histCnt = st_next.histCnt + 4'h1;
                    end
                end
            end
            dfm_pkg::ST_TRIP: begin
                // Latched until a reset method is applied
                if (extHoldDone) begin
                    st_next.state = dfm_pkg::ST_RESET_HOLD;
                end else if (stopEdge) begin
                    st_next.state  = dfm_pkg::ST_RECOVER;
                    st_next.recCnt = 32'h0000_0000;
                end
            end
            dfm_pkg::ST_RESET_HOLD: begin
                if (!extLvl) begin
                    st_next.state  = dfm_pkg::ST_RECOVER;
                    st_next.recCnt = 32'h0000_0000;
                end
            end
            dfm_pkg::ST_RECOVER: begin
                if (extHoldDone) begin
                    st_next.state = dfm_pkg::ST_RESET_HOLD;
                end else if (st_reg.recCnt >= REC_LAST) begin
                    st_next.state = dfm_pkg::ST_RUN;
                end else begin
                    st_next.recCnt = st_reg.recCnt + 32'h0000_0001;
                end
            end
            default: begin
                st_next.state = dfm_pkg::ST_RECOVER;
            end
        endcase

        // Thermal accumulation saturates rather than wrapping to cold
        heatSum = {1'b0, st_reg.heat} + {17'h0_0000, heatAdd};
        if (st_next.state == dfm_pkg::ST_RESET_HOLD ||
            st_next.state == dfm_pkg::ST_RECOVER) begin
            st_next.heat  = 32'h0000_0000;
            st_next.retry = 16'h0000;
        end else begin
            st_next.heat = heatSum[32] ? 32'hffff_ffff : heatSum[31:0];
            if (retryPulse && st_reg.retry != 16'hffff) begin
                st_next.retry = st_reg.retry + 16'h0001;
            end
        end

        // Reset indication flashes while the terminal is held
        if (st_next.state == dfm_pkg::ST_RESET_HOLD) begin
            if (st_reg.blinkCnt >= BLINK_LAST) begin
                st_next.blinkCnt = 32'h0000_0000;
                st_next.blink    = ~st_reg.blink;
            end else begin
                st_next.blinkCnt = st_reg.blinkCnt + 32'h0000_0001;
            end
        end else begin
            st_next.blinkCnt = 32'h0000_0000;
            st_next.blink    = 1'b1;
        end

        // Outputs
        st_next.outputStop = st_next.state != dfm_pkg::ST_RUN;
        st_next.faultOut   = st_next.state == dfm_pkg::ST_TRIP;
        // Start is not re-armed after reset; a held start runs at once
        st_next.runEnable  = !st_next.outputStop &&
                             st_reg.startSync[1];
        st_next.alarmOut   = st_next.alarmEn && alarmReq;
        st_next.warnInd    = warnReq;
        st_next.errorInd   = errReq;
        st_next.dispFlash  = (st_next.state == dfm_pkg::ST_RESET_HOLD) ?
                             st_next.blink : 1'b1;
        if (st_next.state == dfm_pkg::ST_RESET_HOLD) begin
            st_next.disp = dfm_pkg::DISP_RESET;
        end else if (st_next.faultOut) begin
            st_next.disp = dfm_pkg::DISP_FAULT;
        end else if (alarmReq) begin
            st_next.disp = dfm_pkg::DISP_ALARM;
        end else if (warnReq) begin
            st_next.disp = dfm_pkg::DISP_WARN;
        end else if (errReq) begin
            st_next.disp = dfm_pkg::DISP_ERROR;
        end else begin
            st_next.disp = dfm_pkg::DISP_MONITOR;
        end

        st_next.rdData = regRdEn ? readWord(regAddr, st_reg) : 32'h0000_0000;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= CORE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdData  = st_reg.rdData;
    assign outputStop = st_reg.outputStop;
    assign runEnable  = st_reg.runEnable;
    assign faultOut   = st_reg.faultOut;
    assign alarmOut   = st_reg.alarmOut;
    assign errorInd   = st_reg.errorInd;
    assign warnInd    = st_reg.warnInd;
    assign dispMode   = st_reg.disp;
    assign dispFlash  = st_reg.dispFlash;
    assign faultCode  = st_reg.lastCode;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cbDfm @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_HIST_CLEAR:
        assert property (regWrEn && regAddr == dfm_pkg::REG_CTRL &&
                         regWrData[dfm_pkg::CTRL_HIST_CLR_BIT] && !tripNow
                         |=> st_reg.histCnt == 4'h0 && st_reg.hist == '0)
        else $error("history not erased by clear write");

    AST_TRIP_HELD:
        assert property (st_reg.state == dfm_pkg::ST_TRIP && !stopEdge &&
                         !extHoldDone |=> outputStop && faultOut)
        else $error("trip released without a reset");

    AST_ERR_NO_TRIP:
        assert property (st_reg.state == dfm_pkg::ST_RUN && errReq &&
                         faultReq == '0 && !warnEsc && !extHoldDone
                         |=> !outputStop && !faultOut)
        else $error("error message tripped the output");

    AST_ALARM_OUT:
        assert property (alarmReq && st_reg.alarmEn && !extHoldDone &&
                         !(regWrEn && regAddr == dfm_pkg::REG_CTRL)
                         |=> alarmOut && (faultOut || !outputStop ||
                             $past(st_reg.state) != dfm_pkg::ST_RUN))
        else $error("alarm output missing or alarm tripped");

    AST_FAULT_TRIP:
        assert property (tripNow && !extHoldDone
                         |=> faultOut && outputStop &&
                             faultCode == $past(tripCode))
        else $error("fault did not trip with its code");

    AST_DISP_FAULT:
        assert property (faultOut |-> dispMode == dfm_pkg::DISP_FAULT)
        else $error("display not on fault indication");

    AST_RESET_ZERO:
        assert property (st_reg.state == dfm_pkg::ST_RECOVER
                         |-> st_reg.heat == 32'h0 && st_reg.retry == 16'h0)
        else $error("reset did not clear heat and retries");

    AST_RECOVER_TIME:
        assert property (st_reg.state == dfm_pkg::ST_RECOVER &&
                         st_reg.recCnt >= REC_LAST && !extHoldDone
                         |=> st_reg.state == dfm_pkg::ST_RUN)
        else $error("recovery did not end on time");

    AST_STOP_IN_RUN:
        assert property (st_reg.state == dfm_pkg::ST_RUN && stopEdge &&
                         !extHoldDone
                         |=> st_reg.state != dfm_pkg::ST_RECOVER)
        else $error("stop key reset without a fault");

    AST_EXT_HOLD:
        assert property (st_reg.state == dfm_pkg::ST_RESET_HOLD && extLvl
                         |=> st_reg.state == dfm_pkg::ST_RESET_HOLD &&
                             dispMode == dfm_pkg::DISP_RESET)
        else $error("left reset while terminal held");

    AST_HIST_PUSH:
        assert property (tripNow && !extHoldDone
                         |=> st_reg.hist[0] == $past(tripCode) &&
                             st_reg.histCnt != 4'h0)
        else $error("fault not pushed as newest record");

endmodule // dfm_trip_manager

`default_nettype wire

// file: bench/dfm_panel_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Panel stop key and terminal inputs
// ----------------------------------------------------------------
module dfm_panel_model (
    // Clock
    input  wire logic ref_clk,
    // Pins
    output logic      panelStopKey,
    output logic      extResetIn,
    output logic      startCmd
);
    initial begin
        panelStopKey = 1'b0;
        extResetIn   = 1'b0;
        startCmd     = 1'b0;
    end

    task automatic setStart(input logic v);
        @(posedge ref_clk) startCmd <= v;
    endtask

    // Start goes off first, else the reset would restart the motor
    task automatic pressStop();
        @(posedge ref_clk) startCmd <= 1'b0;
        @(posedge ref_clk) panelStopKey <= 1'b1;
        repeat (4) @(posedge ref_clk);
        panelStopKey <= 1'b0;
    endtask

    // The bench passes a hold longer than the scaled minimum
    task automatic holdReset(input int cyc);
        @(posedge ref_clk) startCmd <= 1'b0;
        extResetIn <= 1'b1;
        repeat (cyc) @(posedge ref_clk);
        extResetIn <= 1'b0;
    endtask
endmodule // dfm_panel_model

`default_nettype wire

// file: bench/test_drive_fault_trip_manager.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module test_drive_fault_trip_manager;
    logic ref_clk, rst, regWrEn, regRdEn, warnReq, alarmReq, errReq;
    logic retryPulse, panelStopKey, extResetIn, startCmd, outputStop;
    logic runEnable, faultOut, alarmOut, errorInd, warnInd, dispFlash, f;
    logic [7:0]  regAddr, faultCode;
    logic [31:0] regWrData, regRdData, d, h;
    logic [26:0] faultReq;
    logic [15:0] heatAdd;
    logic [2:0]  dispMode;
    int          miscompares, checks, n;
    // Row i: source bit i in, fault code out
    logic [7:0] codes [27] = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22,
        8'h30, 8'h31, 8'h40, 8'h52, 8'h60, 8'h61, 8'h70, 8'h80, 8'h81,
        8'h90, 8'h91, 8'hb0, 8'hb1, 8'hb2, 8'hf5, 8'hc0, 8'hc4, 8'hc5,
        8'hc7, 8'hd0, 8'he6};

    dfm_panel_model pnl_u (.ref_clk, .panelStopKey, .extResetIn, .startCmd);
    dfm_trip_manager #(.EXT_HOLD_CYC(20), .RECOVER_CYC(30), .BLINK_CYC(4),
        .WARN_ESC_CYC(10)) dut_u (.ref_clk, .rst, .regAddr, .regWrData,
        .regWrEn, .regRdEn, .regRdData, .faultReq, .warnReq, .alarmReq,
        .errReq, .heatAdd, .retryPulse, .panelStopKey, .extResetIn,
        .startCmd, .outputStop, .runEnable, .faultOut, .alarmOut, .errorInd,
        .warnInd, .dispMode, .dispFlash, .faultCode);

    always #4 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Bus and sequencing tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk) regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge ref_clk) regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk) regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk) regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic waitRun();
        n = 0;
        while (outputStop !== 1'b0 && n < 200) begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {ref_clk, regWrEn, regRdEn, warnReq, alarmReq, errReq} = '0;
        {regAddr, regWrData, faultReq, retryPulse} = '0;
        {miscompares, checks} = '0;
        heatAdd = 16'h0001;
        rst = 1'b1;
        tick(12);
        `CHK("stopRst", 1'b1, outputStop)
        `CHK("codeRst", 8'h00, faultCode)
        @(posedge ref_clk) rst <= 1'b0;
        pnl_u.setStart(1'b1);
        waitRun();
        tick(4);
        `CHK("runEn", 1'b1, runEnable)
        `CHK("flashRun", 1'b1, dispFlash)
        for (int i = 0; i < 27; i++) begin
            @(posedge ref_clk) faultReq <= 27'd1 << i;
            @(posedge ref_clk) faultReq <= '0;
            #1 `CHK("code", codes[i], faultCode)
            `CHK("faultOut", 1'b1, faultOut)
            `CHK("dispFault", 3'h4, dispMode)
            tick(6);
            `CHK("held", 1'b1, outputStop)
            pnl_u.pressStop();
            #1 `CHK("keyRst", 1'b0, faultOut)
            waitRun();
            `CHK("recover", 1'b1, (n >= 26 && n <= 34))
        end
        for (int k = 0; k < 8; k++) begin
            rd(dfm_pkg::REG_HIST_BASE + 8'(4 * k));
            `CHK("hist", {24'h0, codes[26 - k]}, d)
        end
        rd(dfm_pkg::REG_STATUS);
        `CHK("histCnt", 4'h8, d[11:8])
        wr(dfm_pkg::REG_CTRL, 32'h3);
        rd(dfm_pkg::REG_STATUS);
        `CHK("histClr", 4'h0, d[11:8])
        rd(dfm_pkg::REG_HIST_BASE);
        `CHK("histEmpty", 32'h0, d)
        rd(dfm_pkg::REG_CTRL);
        `CHK("ctrl", 32'h1, d)
        rd(8'h14);
        `CHK("unmapped", 32'h0, d)
        pnl_u.pressStop();
        tick(4);
        `CHK("keyInRun", 1'b0, outputStop)
        @(posedge ref_clk) errReq <= 1'b1;
        tick(2);
        `CHK("errInd", 1'b1, errorInd)
        `CHK("dispErr", 3'h1, dispMode)
        @(posedge ref_clk) warnReq <= 1'b1;
        tick(2);
        `CHK("dispWarn", 3'h2, dispMode)
        `CHK("warnInd", 1'b1, warnInd)
        @(posedge ref_clk) alarmReq <= 1'b1;
        tick(2);
        `CHK("dispAlarm", 3'h3, dispMode)
        `CHK("alarmOut", 1'b1, alarmOut)
        `CHK("noTrip", 1'b0, outputStop)
        @(posedge ref_clk) alarmReq <= 1'b0;
        errReq <= 1'b0;
        n = 0;
        while (faultOut !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1 n++;
        end
        `CHK("escalate", 8'h60, faultCode)
        @(posedge ref_clk) warnReq <= 1'b0;
        pnl_u.pressStop();
        waitRun();
        // No increment means the accumulated heat must stand still
        @(posedge ref_clk) heatAdd <= 16'h0000;
        rd(dfm_pkg::REG_HEAT);
        h = d;
        rd(dfm_pkg::REG_HEAT);
        `CHK("heatHold", h, d)
        @(posedge ref_clk) heatAdd <= 16'h0010;
        retryPulse <= 1'b1;
        @(posedge ref_clk) retryPulse <= 1'b0;
        rd(dfm_pkg::REG_RETRY);
        `CHK("retry", 32'h1, d)
        rd(dfm_pkg::REG_HEAT);
        `CHK("heatUp", 1'b1, (d > h))
        // Sample the reset indication twice, half a blink period (BLINK_CYC cycles) apart
        fork
            pnl_u.holdReset(40);
            begin
                tick(30);
                f = dispFlash;
                tick(4);
                `CHK("flashBlink", ~f, dispFlash)
            end
        join
        #1 `CHK("dispRst", 3'h5, dispMode)
        `CHK("stopRst", 1'b1, outputStop)
        rd(dfm_pkg::REG_HEAT);
        `CHK("heatClr", 32'h0, d)
        rd(dfm_pkg::REG_RETRY);
        `CHK("retryClr", 32'h0, d)
        waitRun();
        `CHK("extRecover", 1'b0, outputStop)
        summarize();
    end

    // Loop of 27 trips takes about 1200 cycles; this leaves ample slack
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        summarize();
    end
endmodule // test_drive_fault_trip_manager

`default_nettype wire
